/* File: rtl/fwseq_regs.vh */
// Constants for the flash write operation sequencer: register offsets,
// control field positions, reset values and operation timing.
// Assumes a 16-bit register port with word offsets on a 4-bit address.
`ifndef FWSEQ_REGS_VH
`define FWSEQ_REGS_VH

// Register offsets
`define FWS_OFF_CTRL0H    4'h1
`define FWS_OFF_SMASK_L   4'h2
`define FWS_OFF_SMASK_H   4'h3
`define FWS_OFF_ADDR_L    4'h4
`define FWS_OFF_ADDR_H    4'h5
`define FWS_OFF_D0_L      4'h6
`define FWS_OFF_D0_H      4'h7
`define FWS_OFF_D1_L      4'h8
`define FWS_OFF_D1_H      4'h9
`define FWS_OFF_ERROR     4'hA
`define FWS_OFF_STATUS    4'hB

// Control zero high fields
`define FWS_B_START       15
`define FWS_B_SUSPEND_REQUEST        14
`define FWS_B_WPG         13
`define FWS_B_DOUBLE_WORD_PROGRAM_SELECT        12
`define FWS_B_SER         11
`define FWS_B_SPR         8
`define FWS_B_MOD         7
`define FWS_B_RESUME_ERROR_FLAG       0

// Operation codes, one-hot: word, double word, erase, protection
`define FWS_OP_WORD       4'h8
`define FWS_OP_DWORD      4'h4
`define FWS_OP_ERASE      4'h2
`define FWS_OP_PROT       4'h1

// Protection register addresses
`define FWS_PA_WPROT      32'h000E_DFB4
`define FWS_PA_ACCESS     32'h000E_DFB8
`define FWS_PA_DISABLE    32'h000E_DFBC

// Reset values
`define FWS_RST_WORD      16'h0000
`define FWS_RST_NV        16'hFFFF

// Timing
`define FWS_CLK_MHZ       200
`define FWS_PROG_TIME_NS  10000
`define FWS_ERASE_TIME_NS 100000
`define FWS_PROG_CYCLES   ((`FWS_PROG_TIME_NS * `FWS_CLK_MHZ) / 1000)
`define FWS_ERASE_CYCLES  ((`FWS_ERASE_TIME_NS * `FWS_CLK_MHZ) / 1000)

`endif

/* File: rtl/fwseq_timer.v */
// Operation duration counter for the flash write sequencer.
// Assumes the caller holds run low while an operation is paused.
`timescale 1ns/100ps
module fwseq_timer #(
   parameter TW = 16
) (
   clk,
   rst,
   load,
   load_val,
   run,
   left_r,
   done_r
);
   input  wire          clk;
   input  wire          rst;
   input  wire          load;
   input  wire [TW-1:0] load_val;
   input  wire          run;
   output reg  [TW-1:0] left_r;
   output reg           done_r;

   ////////////////////////////////////////////////////////////////////////
   // Load wins over counting so a stale count never fires a done
   always @(posedge clk) begin
      if (rst) begin
         left_r <= {TW{1'b0}};
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (load) begin
            left_r <= load_val;
         end else if (run && (left_r != {TW{1'b0}})) begin
            left_r <= left_r - {{(TW-1){1'b0}}, 1'b1};
            done_r <= (left_r == {{(TW-1){1'b0}}, 1'b1});
         end
      end
   end
endmodule

/* File: rtl/fwseq_top.v */
// Flash write operation sequencer: control, operand and protection
// registers, operation launch, suspend, resume and erase-suspend program.
// Assumes a same-clock register master and a flash array that follows
// the op, address and data outputs while flash_run_r is high.
`timescale 1ns/100ps
`include "fwseq_regs.vh"
module fwseq_top #(
   parameter PROG_CYCLES  = `FWS_PROG_CYCLES,
   parameter ERASE_CYCLES = `FWS_ERASE_CYCLES
) (
   clk,
   rst,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata_r,
   flash_run_r,
   flash_op_r,
   flash_module_r,
   flash_addr_r,
   flash_data_r,
   flash_sector_r,
   flash_done_r,
   flash_abort_r,
   write_protect_r,
   access_protect_r,
   debug_protect_r
);
   input  wire        clk;
   input  wire        rst;
   input  wire [3:0]  reg_addr;
   input  wire [15:0] reg_wdata;
   input  wire        reg_wr;
   input  wire        reg_rd;
   output reg  [15:0] reg_rdata_r;
   output reg         flash_run_r;
   output reg  [3:0]  flash_op_r;
   output reg         flash_module_r;
   output reg  [31:0] flash_addr_r;
   output reg  [63:0] flash_data_r;
   output reg  [31:0] flash_sector_r;
   output reg         flash_done_r;
   output reg         flash_abort_r;
   output reg  [15:0] write_protect_r;
   output reg         access_protect_r;
   output reg         debug_protect_r;

   // Sequencer states
   localparam [4:0] S_IDLE  = 5'h01;
   localparam [4:0] S_RUN   = 5'h02;
   localparam [4:0] S_ESUSP = 5'h04;
   localparam [4:0] S_PSUSP = 5'h08;
   localparam [4:0] S_NEST  = 5'h10;
   localparam       TW      = 16;

   reg  [4:0]    state_r;
   reg           start_r;
   reg           suspend_request_r;
   reg  [3:0]    sel_r;
   reg           mod_r;
   reg  [3:0]    op_r;
   reg  [3:0]    orig_sel_r;
   reg           orig_mod_r;
   reg  [15:0]   smask_l_r;
   reg  [15:0]   smask_h_r;
   reg  [15:0]   addr_l_r;
   reg  [15:0]   addr_h_r;
   reg  [15:0]   d0_l_r;
   reg  [15:0]   d0_h_r;
   reg  [15:0]   d1_l_r;
   reg  [15:0]   d1_h_r;
   reg           resume_error_flag_r;
   reg  [TW-1:0] saved_r;
   reg           tmr_load_r;
   reg  [TW-1:0] tmr_val_r;
   reg  [15:0]   wprot_nv_r;
   reg           accp_nv_r;
   reg           dbgp_nv_r;
   reg  [15:0]   pds_r;
   reg  [15:0]   pen_r;
   reg           prot_dis_r;
   wire [TW-1:0] tmr_left;
   wire          tmr_done;
   wire [15:0]   pds_ok;
   wire [15:0]   pen_ok;
   wire [15:0]   dis_vec;
   wire [31:0]   prog_full  = PROG_CYCLES;
   wire [31:0]   erase_full = ERASE_CYCLES;
   wire [TW-1:0] prog_cnt   = prog_full[TW-1:0];
   wire [TW-1:0] erase_cnt  = erase_full[TW-1:0];

   // Decoded control write fields
   wire       wr_ctl  = reg_wr && (reg_addr == `FWS_OFF_CTRL0H);
   wire       w_start = reg_wdata[`FWS_B_START];
   wire       w_suspend_request  = reg_wdata[`FWS_B_SUSPEND_REQUEST];
   wire       w_mod   = reg_wdata[`FWS_B_MOD];
   wire [3:0] w_sel   = {reg_wdata[`FWS_B_WPG], reg_wdata[`FWS_B_DOUBLE_WORD_PROGRAM_SELECT],
                         reg_wdata[`FWS_B_SER], reg_wdata[`FWS_B_SPR]};
   wire       w_one   = (w_sel == `FWS_OP_WORD) || (w_sel == `FWS_OP_DWORD) ||
                        (w_sel == `FWS_OP_ERASE) || (w_sel == `FWS_OP_PROT);
   wire       w_prog  = (w_sel == `FWS_OP_WORD) || (w_sel == `FWS_OP_DWORD);
   wire       w_match = (w_sel == orig_sel_r) && (w_mod == orig_mod_r);
   // Operands may change only while nothing runs
   wire       opnd_ok = (state_r == S_IDLE) || (state_r == S_ESUSP);

   ////////////////////////////////////////////////////////////////////////
   // Operation duration counter
   fwseq_timer #(
      .TW       (TW)
   ) u_timer (
      .clk      (clk),
      .rst      (rst),
      .load     (tmr_load_r),
      .load_val (tmr_val_r),
      .run      (flash_run_r),
      .left_r   (tmr_left),
      .done_r   (tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // Which protection bits may be cleared, and whether protection is off
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_prot
         if (gi == 0) begin : g_first
            assign pds_ok[gi] = ~accp_nv_r & ~dbgp_nv_r;
         end else begin : g_rest
            assign pds_ok[gi] = ~pen_r[gi-1];
         end
         assign pen_ok[gi]  = ~pds_r[gi];
         assign dis_vec[gi] = ~pds_r[gi] & pen_r[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Latch an operation onto the flash outputs and arm the timer
   task launch;
      input [3:0] sel;
      input       mdl;
      begin
         flash_op_r     <= sel;
         flash_module_r <= mdl;
         flash_run_r    <= 1'b1;
         start_r        <= 1'b1;
         op_r           <= sel;
         tmr_load_r     <= 1'b1;
         tmr_val_r      <= (sel == `FWS_OP_ERASE) ? erase_cnt : prog_cnt;
         // Double words always land on an even word
         flash_addr_r   <= {addr_h_r, addr_l_r[15:3],
                            addr_l_r[2] & (sel != `FWS_OP_DWORD), addr_l_r[1:0]};
         flash_data_r   <= {d1_h_r, d1_l_r, d0_h_r, d0_l_r};
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Sequencer, control and operand registers
   always @(posedge clk) begin
      if (rst) begin
         state_r        <= S_IDLE;
         start_r        <= 1'b0;
         suspend_request_r         <= 1'b0;
         sel_r          <= 4'h0;
         mod_r          <= 1'b0;
         op_r           <= 4'h0;
         orig_sel_r     <= 4'h0;
         orig_mod_r     <= 1'b0;
         smask_l_r      <= `FWS_RST_WORD;
         smask_h_r      <= `FWS_RST_WORD;
         addr_l_r       <= `FWS_RST_WORD;
         addr_h_r       <= `FWS_RST_WORD;
         d0_l_r         <= `FWS_RST_WORD;
         d0_h_r         <= `FWS_RST_WORD;
         d1_l_r         <= `FWS_RST_WORD;
         d1_h_r         <= `FWS_RST_WORD;
         resume_error_flag_r        <= 1'b0;
         saved_r        <= {TW{1'b0}};
         tmr_load_r     <= 1'b0;
         tmr_val_r      <= {TW{1'b0}};
         flash_run_r    <= 1'b0;
         flash_op_r     <= 4'h0;
         flash_module_r <= 1'b0;
         flash_addr_r   <= 32'h0000_0000;
         flash_data_r   <= 64'h0000_0000_0000_0000;
         flash_done_r   <= 1'b0;
         flash_abort_r  <= 1'b0;
         wprot_nv_r     <= `FWS_RST_NV;
         accp_nv_r      <= 1'b1;
         dbgp_nv_r      <= 1'b1;
         pds_r          <= `FWS_RST_NV;
         pen_r          <= `FWS_RST_NV;
      end else begin
         tmr_load_r    <= 1'b0;
         flash_done_r  <= 1'b0;
         flash_abort_r <= 1'b0;

         // Operand writes, blocked while an operation holds them
         if (reg_wr && opnd_ok) begin
            case (reg_addr)
               `FWS_OFF_ADDR_L: addr_l_r <= reg_wdata;
               `FWS_OFF_ADDR_H: addr_h_r <= reg_wdata;
               `FWS_OFF_D0_L:   d0_l_r   <= reg_wdata;
               `FWS_OFF_D0_H:   d0_h_r   <= reg_wdata;
               `FWS_OFF_D1_L:   d1_l_r   <= reg_wdata;
               `FWS_OFF_D1_H:   d1_h_r   <= reg_wdata;
               default: begin
               end
            endcase
         end
         // Masks belong to a pending erase, so only idle may touch them
         if (reg_wr && (state_r == S_IDLE)) begin
            if (reg_addr == `FWS_OFF_SMASK_L) begin
               smask_l_r <= reg_wdata;
            end
            if (reg_addr == `FWS_OFF_SMASK_H) begin
               smask_h_r <= reg_wdata;
            end
         end
         // Error flag: write one clears, a new abort in the same cycle wins
         if (reg_wr && (reg_addr == `FWS_OFF_ERROR) && reg_wdata[`FWS_B_RESUME_ERROR_FLAG]) begin
            resume_error_flag_r <= 1'b0;
         end

         case (state_r)
            S_IDLE: begin
               if (wr_ctl) begin
                  // Dropping a select bit simply cancels it here
                  sel_r  <= w_sel;
                  mod_r  <= w_mod;
                  suspend_request_r <= w_suspend_request;
                  if (w_start && w_one && !w_suspend_request) begin
                     orig_sel_r <= w_sel;
                     orig_mod_r <= w_mod;
                     state_r    <= S_RUN;
                     launch(w_sel, w_mod);
                  end
               end
            end
            S_RUN: begin
               if (tmr_done) begin
                  flash_run_r  <= 1'b0;
                  flash_done_r <= 1'b1;
                  start_r      <= 1'b0;
                  sel_r        <= 4'h0;
                  state_r      <= S_IDLE;
                  if (op_r == `FWS_OP_ERASE) begin
                     smask_l_r <= `FWS_RST_WORD;
                     smask_h_r <= `FWS_RST_WORD;
                  end
                  if ((op_r == `FWS_OP_PROT) && (flash_addr_r == `FWS_PA_WPROT)) begin
                     wprot_nv_r <= flash_data_r[15:0];
                  end
                  if ((op_r == `FWS_OP_PROT) && (flash_addr_r == `FWS_PA_ACCESS)) begin
                     accp_nv_r <= flash_data_r[0];
                     dbgp_nv_r <= flash_data_r[1];
                  end
                  if ((op_r == `FWS_OP_PROT) && (flash_addr_r == `FWS_PA_DISABLE)) begin
                     // Bits only ever clear, so sixteen pairs bound the cycles
                     pds_r <= pds_r & ~(~flash_data_r[15:0] & pds_ok);
                     pen_r <= pen_r & ~(~flash_data_r[31:16] & pen_ok);
                  end
               end else if (wr_ctl && w_suspend_request && (op_r != `FWS_OP_PROT)) begin
                  // Pause and keep the remaining time for the resume
                  flash_run_r <= 1'b0;
                  suspend_request_r      <= 1'b1;
                  saved_r     <= tmr_left;
                  state_r     <= (op_r == `FWS_OP_ERASE) ? S_ESUSP : S_PSUSP;
               end
            end
            S_ESUSP: begin
               if (wr_ctl) begin
                  sel_r  <= w_sel;
                  mod_r  <= w_mod;
                  suspend_request_r <= w_suspend_request;
                  if (w_start && w_match) begin
                     // Same setup as before: continue the original erase
                     suspend_request_r      <= 1'b0;
                     start_r     <= 1'b1;
                     flash_run_r <= 1'b1;
                     op_r        <= orig_sel_r;
                     flash_op_r  <= orig_sel_r;
                     tmr_load_r  <= 1'b1;
                     tmr_val_r   <= saved_r;
                     state_r     <= S_RUN;
                  end else if (w_start && w_prog && !w_suspend_request) begin
                     // Program another sector while the erase waits
                     state_r <= S_NEST;
                     launch(w_sel, w_mod);
                  end else if (w_start) begin
                     resume_error_flag_r       <= 1'b1;
                     flash_abort_r <= 1'b1;
                     start_r       <= 1'b0;
                     suspend_request_r        <= 1'b0;
                     sel_r         <= 4'h0;
                     state_r       <= S_IDLE;
                  end
               end
            end
            S_PSUSP: begin
               if (wr_ctl) begin
                  sel_r  <= w_sel;
                  mod_r  <= w_mod;
                  suspend_request_r <= w_suspend_request;
                  if (w_start && w_match) begin
                     suspend_request_r      <= 1'b0;
                     start_r     <= 1'b1;
                     flash_run_r <= 1'b1;
                     tmr_load_r  <= 1'b1;
                     tmr_val_r   <= saved_r;
                     state_r     <= S_RUN;
                  end else if (w_start) begin
                     resume_error_flag_r       <= 1'b1;
                     flash_abort_r <= 1'b1;
                     start_r       <= 1'b0;
                     suspend_request_r        <= 1'b0;
                     sel_r         <= 4'h0;
                     state_r       <= S_IDLE;
                  end
               end
            end
            S_NEST: begin
               // Control writes are ignored: this program cannot pause
               if (tmr_done) begin
                  flash_run_r  <= 1'b0;
                  flash_done_r <= 1'b1;
                  start_r      <= 1'b0;
                  sel_r        <= 4'h0;
                  op_r         <= orig_sel_r;
                  flash_op_r   <= orig_sel_r;
                  state_r      <= S_ESUSP;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Protection outputs and sector masks toward the array
   always @(posedge clk) begin
      if (rst) begin
         prot_dis_r       <= 1'b0;
         write_protect_r  <= 16'h0000;
         access_protect_r <= 1'b0;
         debug_protect_r  <= 1'b0;
         flash_sector_r   <= 32'h0000_0000;
      end else begin
         prot_dis_r       <= |dis_vec;
         write_protect_r  <= ~wprot_nv_r;
         access_protect_r <= ~accp_nv_r & ~prot_dis_r;
         debug_protect_r  <= ~dbgp_nv_r & ~prot_dis_r;
         flash_sector_r   <= {smask_h_r, smask_l_r};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register read port, data one cycle after the strobe
   always @(posedge clk) begin
      if (rst) begin
         reg_rdata_r <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `FWS_OFF_CTRL0H:  reg_rdata_r <= {start_r, suspend_request_r, sel_r[3:1], 2'b00,
                                              sel_r[0], mod_r, 7'h00};
            `FWS_OFF_SMASK_L: reg_rdata_r <= smask_l_r;
            `FWS_OFF_SMASK_H: reg_rdata_r <= smask_h_r;
            `FWS_OFF_ADDR_L:  reg_rdata_r <= addr_l_r;
            `FWS_OFF_ADDR_H:  reg_rdata_r <= addr_h_r;
            `FWS_OFF_D0_L:    reg_rdata_r <= d0_l_r;
            `FWS_OFF_D0_H:    reg_rdata_r <= d0_h_r;
            `FWS_OFF_D1_L:    reg_rdata_r <= d1_l_r;
            `FWS_OFF_D1_H:    reg_rdata_r <= d1_h_r;
            `FWS_OFF_ERROR:   reg_rdata_r <= {15'h0000, resume_error_flag_r};
            `FWS_OFF_STATUS:  reg_rdata_r <= {10'h000, prot_dis_r, ~accp_nv_r,
                                              state_r[4], state_r[3], state_r[2],
                                              ~state_r[0]};
            default:          reg_rdata_r <= 16'h0000;
         endcase
      end else begin
         reg_rdata_r <= 16'h0000;
      end
   end
endmodule

/* File: test/fwseq_checker.sv */
// Checker: timing relations at the flash write sequencer ports.
// Assumes one clock domain; bound into fwseq_top below.
`timescale 1ns/100ps
module fwseq_checker #(
   parameter PROG_CYCLES  = 20,
   parameter ERASE_CYCLES = 60
) (
   input wire        clk,
   input wire        rst,
   input wire [3:0]  reg_addr,
   input wire [15:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [15:0] reg_rdata_r,
   input wire        flash_run_r,
   input wire [3:0]  flash_op_r,
   input wire [31:0] flash_addr_r,
   input wire [63:0] flash_data_r,
   input wire [31:0] flash_sector_r,
   input wire        flash_done_r,
   input wire        flash_abort_r,
   input wire [15:0] write_protect_r
);
   // Slack covers launch and completion cycles, not suspension time
   localparam int PMAX = PROG_CYCLES + 8;
   localparam int EMAX = ERASE_CYCLES + 8;
   // Start write decode
   wire start_wr = reg_wr && reg_addr == 4'h1 && reg_wdata[15];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   // Launch and erase completion steps
   sequence s_launch;
      start_wr ##1 $rose(flash_run_r);
   endsequence
   sequence s_erase_end;
      flash_done_r && $past(flash_op_r) == 4'h2;
   endsequence
   property p_prog_end;
      s_launch ##0 flash_op_r != 4'h2 |-> ##[1:PMAX] !flash_run_r;
   endproperty
   property p_erase_end;
      s_launch ##0 flash_op_r == 4'h2 |-> ##[1:EMAX] !flash_run_r;
   endproperty
   ////////////////////////////////////////////////////////////////////////////////
   // Port relations
   AST_READ: assert property (!$past(reg_rd) |-> reg_rdata_r == 16'h0000)
      else $error("read data outside its cycle");
   AST_RUN_RISE: assert property ($rose(flash_run_r) |-> $past(start_wr))
      else $error("run began without a start write");
   AST_PROG_END: assert property (p_prog_end)
      else $error("program run too long");
   AST_ERASE_END: assert property (p_erase_end)
      else $error("erase run too long");
   AST_DWORD: assert property (flash_run_r && flash_op_r == 4'h4 |-> !flash_addr_r[2])
      else $error("double word address not aligned");
   AST_HOLD: assert property (flash_run_r && $past(flash_run_r) |->
      $stable({flash_op_r, flash_addr_r, flash_data_r})) else $error("operands moved in run");
   AST_DONE: assert property (flash_done_r |-> $past(flash_run_r) && !flash_run_r)
      else $error("done without a run");
   AST_ABORT: assert property (flash_abort_r |-> !flash_run_r && !flash_done_r)
      else $error("abort while running");
   AST_SECTOR_CLR: assert property (s_erase_end |-> ##[0:3] flash_sector_r == 32'h0000_0000)
      else $error("sector masks kept after erase");
   AST_PROT_CHG: assert property ($changed(write_protect_r) |-> flash_op_r == 4'h1)
      else $error("protection changed outside protection op");
endmodule
bind fwseq_top fwseq_checker #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_chk (
   .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .flash_run_r(flash_run_r),
   .flash_op_r(flash_op_r), .flash_addr_r(flash_addr_r), .flash_data_r(flash_data_r),
   .flash_sector_r(flash_sector_r), .flash_done_r(flash_done_r),
   .flash_abort_r(flash_abort_r), .write_protect_r(write_protect_r)
);

/* File: test/tb_top.sv */
// Self-checking bench for the flash write sequencer.
// Assumes fwseq_top with shortened operation counts and a 200 MHz clock.
`timescale 1ns/100ps
module tb_top;
   localparam PC = 20; // Short program count keeps the run brief
   localparam EC = 60; // Short erase count
   reg         clk = 1'h0;
   reg         rst = 1'h1;
   reg  [3:0]  reg_addr = 4'h0;
   reg  [15:0] reg_wdata = 16'h0000;
   reg         reg_wr = 1'h0;
   reg         reg_rd = 1'h0;
   wire [15:0] reg_rdata_r;
   wire        flash_run_r;
   wire [3:0]  flash_op_r;
   wire        flash_module_r;
   wire [31:0] flash_addr_r;
   wire [63:0] flash_data_r;
   wire [31:0] flash_sector_r;
   wire        flash_done_r;
   wire        flash_abort_r;
   wire [15:0] write_protect_r;
   wire        access_protect_r;
   wire        debug_protect_r;
   integer     mismatches = 0;
   integer     tests_run = 0;
   integer     i;
   reg  [15:0] rv;
   fwseq_top #(.PROG_CYCLES(PC), .ERASE_CYCLES(EC)) dut (
      .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .flash_run_r(flash_run_r),
      .flash_op_r(flash_op_r), .flash_module_r(flash_module_r), .flash_addr_r(flash_addr_r),
      .flash_data_r(flash_data_r), .flash_sector_r(flash_sector_r), .flash_done_r(flash_done_r),
      .flash_abort_r(flash_abort_r), .write_protect_r(write_protect_r),
      .access_protect_r(access_protect_r), .debug_protect_r(debug_protect_r)
   );
   // Clock, 5 ns period
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   // Compare and count
   task check(input [63:0] got, input [63:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // One cycle, sampled after the edge has settled
   task step;
      begin
         @(posedge clk);
         #1;
      end
   endtask
   // Register write, returns once the write has landed
   task wr(input [3:0] a, input [15:0] d);
      begin
         @(posedge clk);
         reg_wr <= 1'h1;
         reg_addr <= a;
         reg_wdata <= d;
         step;
         reg_wr <= 1'h0;
      end
   endtask
   // Register read into rv; data stand only the cycle after the strobe
   task rd(input [3:0] a);
      begin
         @(posedge clk);
         reg_rd <= 1'h1;
         reg_addr <= a;
         step;
         reg_rd <= 1'h0;
         rv = reg_rdata_r;
      end
   endtask
   // Bounded wait for the completion pulse
   task wait_done;
      begin
         i = 0;
         while (flash_done_r !== 1'h1 && i < 400) begin
            step;
            i = i + 1;
         end
         if (i >= 400) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: no completion", $time);
            report_and_stop;
         end
      end
   endtask
   // Select, operands, then start with a second write of the select
   task prog(input [15:0] sel, input [31:0] a, input [31:0] d0, input [31:0] d1);
      begin
         wr(4'h1, sel);
         wr(4'h4, a[15:0]);
         wr(4'h5, a[31:16]);
         wr(4'h6, d0[15:0]);
         wr(4'h7, d0[31:16]);
         wr(4'h8, d1[15:0]);
         wr(4'h9, d1[31:16]);
         wr(4'h1, sel | 16'h8000);
      end
   endtask
   // Protection op, then status bits 5:4 and write protect outputs
   task pstep(input [15:0] a, input [31:0] d, input [17:0] e);
      begin
         prog(16'h0100, {16'h000E, a}, d, 32'h0000_0000);
         wait_done;
         rd(4'hB);
         check({write_protect_r, rv[5:4]}, e);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task t_word;
      begin
         prog(16'h2080, 32'h000C_5554, 32'hAAAA_AAAA, 32'h0000_0000);
         check({flash_run_r, flash_op_r, flash_module_r}, {1'h1, 4'h8, 1'h1});
         check({flash_addr_r, flash_data_r[31:0]}, {32'h000C_5554, 32'hAAAA_AAAA});
         wr(4'h4, 16'h1111); // Operand write while running is dropped
         wr(4'h1, 16'hA080);
         wait_done;
         step;
         check(flash_run_r, 1'h0);
         rd(4'h4);
         check(rv, 16'h5554);
         prog(16'h1080, 32'h0009_555C, 32'h55AA_55AA, 32'hAA55_AA55);
         check({flash_op_r, flash_addr_r}, {4'h4, 32'h0009_5558});
         check(flash_data_r, 64'hAA55_AA55_55AA_55AA);
         wait_done;
         wr(4'h1, 16'h2000);
         wr(4'h1, 16'h0000);
         wr(4'h1, 16'h8000);
         repeat (3) step;
         check(flash_run_r, 1'h0);
      end
   endtask
   // Erase, suspend, nested program, resume, then abort on a bad resume
   task t_erase;
      begin
         wr(4'h1, 16'h0800);
         wr(4'h3, 16'h0003);
         wr(4'h1, 16'h8800);
         step;
         check({flash_op_r, flash_sector_r}, {4'h2, 32'h0003_0000});
         wr(4'h1, 16'h4800);
         step;
         check(flash_run_r, 1'h0);
         rd(4'h3);
         check(rv, 16'h0003);
         wr(4'h1, 16'h0000);
         prog(16'h2000, 32'h000C_5554, 32'h5555_AAAA, 32'h0000_0000);
         check({flash_run_r, flash_data_r[31:0]}, {1'h1, 32'h5555_AAAA});
         rd(4'h1);
         check(rv & 16'h4800, 16'h0000);
         wr(4'h1, 16'hE000);
         step;
         check(flash_run_r, 1'h1);
         wait_done;
         wr(4'h1, 16'h0800);
         wr(4'h1, 16'h8800);
         check({flash_run_r, flash_op_r}, {1'h1, 4'h2});
         wait_done;
         step;
         rd(4'h3);
         check(rv, 16'h0000);
         wr(4'h1, 16'h0800);
         wr(4'h2, 16'h0001);
         wr(4'h1, 16'h8800);
         wr(4'h1, 16'h4800);
         wr(4'h1, 16'h8880);
         rv = 16'h0000;
         for (i = 0; i < 3; i = i + 1) begin
            if (flash_abort_r === 1'h1) rv = 16'h0001;
            step;
         end
         check({rv, flash_run_r}, {16'h0001, 1'h0});
         rd(4'hA);
         check(rv, 16'h0001);
         wr(4'hA, 16'h0001);
         rd(4'hA);
         check(rv, 16'h0000);
      end
   endtask
   task t_prot;
      begin
         pstep(16'hDFB4, 32'hFFFF_FFF0, {16'h000F, 2'h0});
         pstep(16'hDFB8, 32'hFFFF_FFFC, {16'h000F, 2'h1});
         check({access_protect_r, debug_protect_r}, 2'h3);
         pstep(16'hDFBC, 32'hFFFF_FFFE, {16'h000F, 2'h3});
         pstep(16'hDFBC, 32'hFFFE_FFFF, {16'h000F, 2'h1});
         wr(4'hF, 16'h1234);
         rd(4'hF);
         check(rv, 16'h0000);
      end
   endtask
   // Verdict and end of run
   task report_and_stop;
      begin
         $display("mismatches %0d tests_run %0d", mismatches, tests_run);
         if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   // Reset for two cycles, then the scenarios
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rd(4'h1);
      check(rv, 16'h0000);
      t_word;
      t_erase;
      t_prot;
      report_and_stop;
   end
endmodule
